// [adc_trigger_ctrl.sv]
// Control logic of a 10-bit successive-approximation converter: register
// slave, clock source and divider, trigger, sequencer, compare, interrupt.
// Assumes an analog comparator sampled on this clock and a DAC driven here.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_trigger_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // AXI4-Lite write channels
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // AXI4-Lite read channels
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // Clock sources and periodic trigger from outside this domain
  input wire logic local_async_conv_clock_in,
  input wire logic alternate_conv_clock_in,
  input wire logic periodic_overflow_in,
  // Analog core
  input wire logic comparator_in,
  output logic [9:0] dac_code_out,
  output logic [4:0] channel_select_out,
  output logic [15:0] ext_channel_sel_out,
  output logic [15:0] pin_analog_enable_out,
  output logic low_ref_sel_out,
  output logic temp_sensor_sel_out,
  output logic bandgap_sel_out,
  output logic sample_out,
  output logic converter_off_out,
  // Interrupt
  output logic irq_out
);

  // ------------------------------
  // Reset release
  // ------------------------------
  logic [1:0] rst_pipe;
  logic rst_b;

  // Release is synchronous so no flop sees a partial reset edge
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_b = rst_pipe[1];

  // ------------------------------
  // Input synchronisers (three stages, stage 2 and 3 must agree)
  // ------------------------------
  logic [2:0] sync_in;
  logic [2:0] sync_s1, sync_s2, sync_s3, sync_val;
  logic [2:0] next_sync_val;
  logic [2:0] sync_rise;

  assign sync_in = {periodic_overflow_in, alternate_conv_clock_in, local_async_conv_clock_in};

  // Filtered level moves only when the last two stages agree
  always_comb begin
    next_sync_val = sync_val;
    for (int i = 0; i < 3; i++) begin
      if (sync_s2[i] == sync_s3[i]) begin
        next_sync_val[i] = sync_s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      sync_s1 <= 3'b000;
      sync_s2 <= 3'b000;
      sync_s3 <= 3'b000;
      sync_val <= 3'b000;
    end else begin
      sync_s1 <= sync_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      sync_val <= next_sync_val;
    end
  end
  assign sync_rise = next_sync_val & ~sync_val;

  // ------------------------------
  // Register bus state
  // ------------------------------
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_en, rd_en;

  // Control and status registers
  logic [4:0] chan, next_chan;
  logic cont, next_cont;
  logic done_flag, next_done_flag;
  logic hw_en, next_hw_en, cmp_en, next_cmp_en, cmp_ge, next_cmp_ge;
  logic [9:0] result, next_result, cmp_val, next_cmp_val;
  logic [4:0] clk_cfg, next_clk_cfg;
  logic [15:0] pin_en, next_pin_en;
  logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;

  // Sequencer state
  conv_state_e state, next_state;
  logic [2:0] samp_cnt, next_samp_cnt;
  logic [9:0] sar, next_sar;
  logic [3:0] bit_idx, next_bit_idx;
  logic half_tgl, next_half_tgl;
  logic [2:0] div_cnt, next_div_cnt;
  logic trig_phase, next_trig_phase;

  // Combinational helpers
  logic [31:0] strb_mask;
  logic src_tick, conv_tick, hw_trig;
  logic [2:0] div_max;
  logic [9:0] raw, fmt;
  logic cmp_true, finish;

  assign awready_out = !aw_held;
  assign wready_out = !w_held;
  assign arready_out = !rvalid_out;
  assign wr_en = aw_held && w_held && !bvalid_out;
  assign rd_en = arvalid_in && !rvalid_out;
  assign strb_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  // ------------------------------
  // Conversion clock: source select and divider
  // ------------------------------
  // Source ticks are enables; the block keeps one clock domain
  always_comb begin
    next_half_tgl = !half_tgl;
    case (clk_src_e'(clk_cfg[1:0]))
      SRC_BUS: src_tick = 1'b1;
      SRC_BUS_HALF: src_tick = half_tgl;
      SRC_LOCAL: src_tick = sync_rise[0];
      default: src_tick = sync_rise[1];
    endcase
    div_max = 3'((4'd1 << clk_cfg[3:2]) - 4'd1);
    conv_tick = src_tick && (div_cnt == div_max);
    next_div_cnt = div_cnt;
    if (src_tick) begin
      next_div_cnt = conv_tick ? 3'd0 : 3'(div_cnt + 3'd1);
    end
    // Counter output toggles per overflow; only its rising edge triggers
    next_trig_phase = trig_phase ^ sync_rise[2];
    hw_trig = sync_rise[2] && !trig_phase && hw_en;
  end

  // ------------------------------
  // Result shaping and compare
  // ------------------------------
  always_comb begin
    raw = sar;
    if (bit_idx < 4'd10) begin
      raw[bit_idx] = comparator_in;
    end
    if (chan <= `ADC_CHAN_LAST_LOW && chan > `ADC_CHAN_LAST_EXT) begin
      raw = 10'h000;
    end else if (chan == `ADC_CHAN_LOW_REF) begin
      raw = 10'h000;
    end else if (chan == `ADC_CHAN_HIGH_REF) begin
      raw = 10'h3FF;
    end
    // Reserved codes keep whatever the comparator produced
    fmt = clk_cfg[`ADC_CFG_MODE8_BIT] ? {2'b00, raw[9:2]} : raw;
    cmp_true = cmp_ge ? (fmt >= cmp_val) : (fmt < cmp_val);
    finish = (state == ST_CONVERT) && conv_tick && (bit_idx == 4'd0);
  end

  // ------------------------------
  // Bus, registers and sequencer next state
  // ------------------------------
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid_out && !bready_in;
    next_bresp = bresp_out;
    next_rvalid = rvalid_out && !rready_in;
    next_rresp = rresp_out;
    next_rdata = rdata_out;
    next_chan = chan;
    next_cont = cont;
    next_done_flag = done_flag;
    next_hw_en = hw_en;
    next_cmp_en = cmp_en;
    next_cmp_ge = cmp_ge;
    next_result = result;
    next_cmp_val = cmp_val;
    next_clk_cfg = clk_cfg;
    next_pin_en = pin_en;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_state = state;
    next_samp_cnt = samp_cnt;
    next_sar = sar;
    next_bit_idx = bit_idx;

    if (awvalid_in && !aw_held) begin
      next_aw_held = 1'b1;
      next_waddr = awaddr_in;
    end
    if (wvalid_in && !w_held) begin
      next_w_held = 1'b1;
      next_wdata = wdata_in;
      next_wstrb = wstrb_in;
    end

    // Read path; result read clears the done flag
    if (rd_en) begin
      next_rvalid = 1'b1;
      next_rresp = `ADC_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (araddr_in == `ADC_OFS_CTRL) begin
        next_rdata = {24'h0, done_flag, 1'b0, cont, chan};
      end else if (araddr_in == `ADC_OFS_TRIG) begin
        next_rdata = {28'h0, (state == ST_SAMPLE || state == ST_CONVERT),
                      cmp_ge, cmp_en, hw_en};
      end else if (araddr_in == `ADC_OFS_RESULT) begin
        next_rdata = {22'h0, result};
        next_done_flag = 1'b0;
      end else if (araddr_in == `ADC_OFS_CMPVAL) begin
        next_rdata = {22'h0, cmp_val};
      end else if (araddr_in == `ADC_OFS_CLKCFG) begin
        next_rdata = {27'h0, clk_cfg};
      end else if (araddr_in == `ADC_OFS_PINEN) begin
        next_rdata = {16'h0000, pin_en};
      end else if (araddr_in == `ADC_OFS_IRQSTAT) begin
        next_rdata = {30'h0, irq_stat};
      end else if (araddr_in == `ADC_OFS_IRQMASK) begin
        next_rdata = {30'h0, irq_mask};
      end else begin
        next_rresp = `ADC_RESP_SLVERR;
      end
    end

    // Sequencer: triggers only count while idle
    case (state)
      ST_OFF: begin
        next_state = ST_OFF;
      end
      ST_IDLE: begin
        if (hw_trig) begin
          next_state = ST_SAMPLE;
          next_samp_cnt = 3'd0;
        end
      end
      ST_SAMPLE: begin
        if (conv_tick) begin
          next_samp_cnt = 3'(samp_cnt + 3'd1);
          if (samp_cnt == `ADC_SAMPLE_TICKS - 3'd1) begin
            next_state = ST_CONVERT;
            next_sar = 10'h200;
            next_bit_idx = 4'd9;
          end
        end
      end
      default: begin
        if (conv_tick) begin
          next_sar = raw;
          if (bit_idx == 4'd0) begin
            next_result = fmt;
            next_bit_idx = 4'd15;
            // Continuous conversions run on; single returns to idle
            next_state = cont ? ST_SAMPLE : ST_IDLE;
            next_samp_cnt = 3'd0;
          end else begin
            next_bit_idx = 4'(bit_idx - 4'd1);
            next_sar[bit_idx - 4'd1] = 1'b1;
          end
        end
      end
    endcase

    // Register writes take priority over the sequencer
    if (wr_en) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `ADC_RESP_OKAY;
      if (waddr == `ADC_OFS_CTRL) begin
        next_chan = wdata[4:0];
        next_cont = wdata[`ADC_CTRL_CONT_BIT];
        next_done_flag = 1'b0;
        next_bit_idx = 4'd15;
        if (wdata[4:0] == `ADC_CHAN_OFF) begin
          next_state = ST_OFF;
        end else if (hw_en) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_SAMPLE;
          next_samp_cnt = 3'd0;
        end
      end else if (waddr == `ADC_OFS_TRIG) begin
        next_hw_en = wdata[`ADC_TRIG_HWEN_BIT];
        next_cmp_en = wdata[`ADC_TRIG_CMPEN_BIT];
        next_cmp_ge = wdata[`ADC_TRIG_CMPGE_BIT];
      end else if (waddr == `ADC_OFS_CMPVAL) begin
        next_cmp_val = 10'((32'(cmp_val) & ~strb_mask) | (wdata & strb_mask));
      end else if (waddr == `ADC_OFS_CLKCFG) begin
        next_clk_cfg = wdata[4:0];
      end else if (waddr == `ADC_OFS_PINEN) begin
        next_pin_en = 16'((32'(pin_en) & ~strb_mask) | (wdata & strb_mask));
      end else if (waddr == `ADC_OFS_IRQSTAT) begin
        next_irq_stat = irq_stat & ~wdata[1:0];
      end else if (waddr == `ADC_OFS_IRQMASK) begin
        next_irq_mask = wdata[1:0];
      end else if (waddr != `ADC_OFS_RESULT) begin
        next_bresp = `ADC_RESP_SLVERR;
      end
    end

    // Completion sets flags; a set wins over a same-cycle clear, but a same-cycle control write drops the set
    if (finish && !(wr_en && waddr == `ADC_OFS_CTRL)) begin
      if (!cmp_en || cmp_true) begin
        next_done_flag = 1'b1;
        next_irq_stat[`ADC_IRQ_DONE_BIT] = 1'b1;
      end
      if (cmp_en && cmp_true) begin
        next_irq_stat[`ADC_IRQ_CMP_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out <= `ADC_RESP_OKAY;
      rvalid_out <= 1'b0;
      rresp_out <= `ADC_RESP_OKAY;
      rdata_out <= 32'h0000_0000;
      chan <= `ADC_CHAN_RESET;
      cont <= 1'b0;
      done_flag <= 1'b0;
      hw_en <= 1'b0;
      cmp_en <= 1'b0;
      cmp_ge <= 1'b0;
      result <= 10'h000;
      cmp_val <= 10'h000;
      clk_cfg <= 5'h00;
      pin_en <= 16'h0000;
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
      state <= ST_OFF;
      samp_cnt <= 3'd0;
      sar <= 10'h000;
      bit_idx <= 4'd15;
      half_tgl <= 1'b0;
      div_cnt <= 3'd0;
      trig_phase <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid_out <= next_bvalid;
      bresp_out <= next_bresp;
      rvalid_out <= next_rvalid;
      rresp_out <= next_rresp;
      rdata_out <= next_rdata;
      chan <= next_chan;
      cont <= next_cont;
      done_flag <= next_done_flag;
      hw_en <= next_hw_en;
      cmp_en <= next_cmp_en;
      cmp_ge <= next_cmp_ge;
      result <= next_result;
      cmp_val <= next_cmp_val;
      clk_cfg <= next_clk_cfg;
      pin_en <= next_pin_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      state <= next_state;
      samp_cnt <= next_samp_cnt;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      half_tgl <= next_half_tgl;
      div_cnt <= next_div_cnt;
      trig_phase <= next_trig_phase;
    end
  end

  // ------------------------------
  // Analog routing outputs
  // ------------------------------
  // One-hot external select; each line gated by its pin enable
  for (genvar g = 0; g < 16; g++) begin : g_ext
    assign ext_channel_sel_out[g] = (chan == 5'(g)) && pin_en[g];
  end

  // Mux controls; bandgap buffer is software's duty before selecting
  assign channel_select_out = chan;
  assign pin_analog_enable_out = pin_en;
  assign low_ref_sel_out = (chan > `ADC_CHAN_LAST_EXT && chan <= `ADC_CHAN_LAST_LOW)
                           || chan == `ADC_CHAN_LOW_REF;
  assign temp_sensor_sel_out = (chan == `ADC_CHAN_TEMP);
  assign bandgap_sel_out = (chan == `ADC_CHAN_BANDGAP);
  assign sample_out = (state == ST_SAMPLE);
  assign converter_off_out = (state == ST_OFF);
  assign dac_code_out = sar;
  assign irq_out = |(irq_stat & irq_mask);

endmodule // adc_trigger_ctrl

// [adc_ctrl_regs.svh]
// Register offsets, field positions, reset values and timing counts for
// the converter control block. Assumes a 32-bit AXI4-Lite register bus.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_TRIG 8'h04
`define ADC_OFS_RESULT 8'h08
`define ADC_OFS_CMPVAL 8'h0C
`define ADC_OFS_CLKCFG 8'h10
`define ADC_OFS_PINEN 8'h14
`define ADC_OFS_IRQSTAT 8'h18
`define ADC_OFS_IRQMASK 8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADC_CTRL_CONT_BIT 5
`define ADC_CTRL_DONE_BIT 7
`define ADC_TRIG_HWEN_BIT 0
`define ADC_TRIG_CMPEN_BIT 1
`define ADC_TRIG_CMPGE_BIT 2
`define ADC_TRIG_BUSY_BIT 3
`define ADC_CFG_MODE8_BIT 4
`define ADC_IRQ_DONE_BIT 0
`define ADC_IRQ_CMP_BIT 1

// ----------------------------------------------------------------------
// Reset values and channel codes
// ----------------------------------------------------------------------
`define ADC_CHAN_RESET 5'h1F
`define ADC_CHAN_OFF 5'h1F
`define ADC_CHAN_LAST_EXT 5'h0F
`define ADC_CHAN_LAST_LOW 5'h15
`define ADC_CHAN_TEMP 5'h1A
`define ADC_CHAN_BANDGAP 5'h1B
`define ADC_CHAN_HIGH_REF 5'h1D
`define ADC_CHAN_LOW_REF 5'h1E

// ----------------------------------------------------------------------
// Timing counts in conversion clock ticks, and bus response codes
// ----------------------------------------------------------------------
`define ADC_SAMPLE_TICKS 3'd4
`define ADC_RESP_OKAY 2'b00
`define ADC_RESP_SLVERR 2'b10

`endif

// [adc_ctrl_pkg.sv]
// Types shared by the converter control block.
// Assumes nothing outside this package.
package adc_ctrl_pkg;
  // Converter sequencer states
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_e;
  // Conversion clock source choices
  typedef enum logic [1:0] {SRC_BUS, SRC_BUS_HALF, SRC_LOCAL, SRC_ALT} clk_src_e;
endpackage

// [adc_far_side_model.sv]
// Far side of the converter: analog level, comparator, clock sources, trigger.
// Assumes the bench sets the level and pulses fire_in for one bus clock.
`timescale 1ns/1ps

module adc_far_side_model (
  // From the bench
  input wire logic ref_clk_in,
  input wire logic fire_in,
  input wire logic [9:0] level_in,
  // From the converter control
  input wire logic [9:0] dac_code_in,
  // To the converter control
  output logic comparator_out,
  output logic overflow_out,
  output logic local_clk_out = 1'b0,
  output logic alt_clk_out = 1'b0
);
  logic [2:0] hold = 3'h0;
  // ------------------------------
  // Analog and clock sources
  // ------------------------------
  // High while the input sits at or above the trial code
  assign comparator_out = (level_in >= dac_code_in);
  // Free running, unrelated to the bus clock; no stop mode exists here
  always #45 local_clk_out = ~local_clk_out;
  always #65 alt_clk_out = ~alt_clk_out;
  // Overflow held four clocks, long enough for a three-flop synchroniser
  always @(posedge ref_clk_in) begin
    if (fire_in) hold <= 3'h4;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign overflow_out = (hold != 3'h0);
endmodule // adc_far_side_model

// [adc_trigger_ctrl_chk.sv]
// Port-level checks of the converter control block.
// Assumes one clock domain and writes that offer address and data together.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_trigger_ctrl_chk (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Register bus
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic bvalid_out,
  input wire logic bready_in,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic rvalid_out,
  // Analog side
  input wire logic [4:0] channel_select_out,
  input wire logic [15:0] ext_channel_sel_out,
  input wire logic [15:0] pin_analog_enable_out,
  input wire logic low_ref_sel_out,
  input wire logic temp_sensor_sel_out,
  input wire logic bandgap_sel_out,
  input wire logic sample_out,
  input wire logic converter_off_out
);
  logic hw_en;
  logic next_hw_en;
  logic wr_both;
  logic [4:0] ch;
  // ------------------------------
  // Helper state
  // ------------------------------
  assign wr_both = awvalid_in && awready_out && wvalid_in && wready_out;
  assign ch = channel_select_out;
  // Trigger enable copy; split address/data writes are not tracked
  always_comb begin
    next_hw_en = hw_en;
    if (wr_both && awaddr_in == `ADC_OFS_TRIG) next_hw_en = wdata_in[`ADC_TRIG_HWEN_BIT];
  end
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) hw_en <= 1'b0;
    else hw_en <= next_hw_en;
  end
  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_ctrl_go;
    wr_both && awaddr_in == `ADC_OFS_CTRL && wdata_in[4:0] != `ADC_CHAN_OFF && !hw_en;
  endsequence
  sequence s_ctrl_off;
    wr_both && awaddr_in == `ADC_OFS_CTRL && wdata_in[4:0] == `ADC_CHAN_OFF;
  endsequence
  a_ext_sel_map: assert property (
    ext_channel_sel_out == ((ch < 5'h10) ? (pin_analog_enable_out & (16'h0001 << ch[3:0])) : 16'h0000))
    else $error("ext select wrong");
  a_low_ref_map: assert property (
    low_ref_sel_out == (ch inside {[5'h10:5'h15], 5'h1E}))
    else $error("low ref select wrong");
  a_reserved_quiet: assert property (
    (ch inside {[5'h16:5'h19], 5'h1C}) |-> !low_ref_sel_out && !temp_sensor_sel_out)
    else $error("reserved code selects");
  a_temp_gap_map: assert property (
    temp_sensor_sel_out == (ch == 5'h1A) && bandgap_sel_out == (ch == 5'h1B))
    else $error("sensor select wrong");
  a_off_no_sample: assert property (
    converter_off_out == (ch == 5'h1F) && !(converter_off_out && sample_out))
    else $error("power down wrong");
  a_sw_start: assert property (s_ctrl_go |-> ##[1:3] sample_out)
    else $error("no sampling");
  a_stop_off: assert property (s_ctrl_off |-> ##[1:3] converter_off_out)
    else $error("no power down");
  a_write_resp: assert property (
    wr_both |=> ##1 bvalid_out ##1 (bvalid_out != $past(bready_in)))
    else $error("write response wrong");
  a_read_resp: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("rvalid late");
endmodule // adc_trigger_ctrl_chk

bind adc_trigger_ctrl adc_trigger_ctrl_chk i_chk (.*);

// [sar_adc_channel_trigger_control_tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module sar_adc_channel_trigger_control_tb_top;
  // ------------------------------
  // Signals
  // ------------------------------
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, fire = 1'b0;
  logic awvalid_in = 1'b0, wvalid_in = 1'b0, bready_in = 1'b0, arvalid_in = 1'b0, rready_in = 1'b0;
  logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000, d;
  logic [3:0] wstrb_in = 4'hF;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out;
  logic [1:0] bresp_out, rresp_out, r;
  logic [31:0] rdata_out;
  logic local_async_conv_clock_in, alternate_conv_clock_in, periodic_overflow_in, comparator_in;
  logic [9:0] dac_code_out, level = 10'h2C5;
  logic [4:0] channel_select_out;
  logic [15:0] ext_channel_sel_out, pin_analog_enable_out;
  logic low_ref_sel_out, temp_sensor_sel_out, bandgap_sel_out, sample_out, converter_off_out;
  int err_total = 0;
  int check_count = 0;
  // Bus clock, 25 ns
  always #12.5 ref_clk_in = ~ref_clk_in;
  adc_trigger_ctrl i_dut (.*);
  adc_far_side_model i_far (.ref_clk_in(ref_clk_in), .fire_in(fire), .level_in(level),
    .dac_code_in(dac_code_out), .comparator_out(comparator_in), .overflow_out(periodic_overflow_in),
    .local_clk_out(local_async_conv_clock_in), .alt_clk_out(alternate_conv_clock_in));
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic give_up(input string what);
    err_total++;
    $display("ERROR %s expected answer seen timeout", what);
    report_and_stop();
  endtask
  // Write; readies sampled mid-cycle, so release follows the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge ref_clk_in);
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    awaddr_in <= a;
    wdata_in <= v;
    bready_in <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(negedge ref_clk_in);
      ta = awvalid_in && awready_out;
      tw = wvalid_in && wready_out;
      got = bready_in && bvalid_out;
      resp = bresp_out;
      @(posedge ref_clk_in);
      if (ta) awvalid_in <= 1'b0;
      if (tw) wvalid_in <= 1'b0;
      if (got) bready_in <= 1'b0;
    end
    if (!got) give_up("write response");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, got;
    got = 1'b0;
    @(posedge ref_clk_in);
    arvalid_in <= 1'b1;
    araddr_in <= a;
    rready_in <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(negedge ref_clk_in);
      ta = arvalid_in && arready_out;
      got = rready_in && rvalid_out;
      v = rdata_out;
      r = rresp_out;
      @(posedge ref_clk_in);
      if (ta) arvalid_in <= 1'b0;
      if (got) rready_in <= 1'b0;
    end
    if (!got) give_up("read data");
  endtask
  // Completion is polled through the done flag, with a bound
  task automatic wait_done;
    for (int n = 0; n < 400; n++) begin
      rd(`ADC_OFS_CTRL, d);
      if (d[`ADC_CTRL_DONE_BIT] === 1'b1) return;
    end
    give_up("done flag");
  endtask
  task automatic no_conv;
    repeat (60) @(posedge ref_clk_in);
    rd(`ADC_OFS_CTRL, d);
    chk("done flag idle", d[`ADC_CTRL_DONE_BIT], 32'h0);
    rd(`ADC_OFS_TRIG, d);
    chk("busy idle", d[`ADC_TRIG_BUSY_BIT], 32'h0);
  endtask
  task automatic run(input logic [4:0] ch, input logic [9:0] exp);
    wr(`ADC_OFS_CTRL, {27'h0, ch}, r);
    wait_done();
    rd(`ADC_OFS_RESULT, d);
    chk("result", d, {22'h0, exp});
    rd(`ADC_OFS_CTRL, d);
    chk("done after read", d[`ADC_CTRL_DONE_BIT], 32'h0);
  endtask
  task automatic pulse;
    @(posedge ref_clk_in);
    fire <= 1'b1;
    @(posedge ref_clk_in);
    fire <= 1'b0;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset;
    rd(`ADC_OFS_CTRL, d);
    chk("control reset", d, 32'h0000_001F);
    chk("off at reset", converter_off_out, 32'h1);
    wr(8'h40, 32'h0000_0001, r);
    chk("unmapped response", r, {30'h0, `ADC_RESP_SLVERR});
    rd(8'h40, d);
    chk("unmapped read", r, {30'h0, `ADC_RESP_SLVERR});
  endtask
  // Every code; pin enables alternate so a missing gate shows up
  task automatic t_chan_map;
    logic [15:0] e;
    wr(`ADC_OFS_PINEN, 32'h0000_AAAA, r);
    for (int n = 0; n < 32; n++) begin
      wr(`ADC_OFS_CTRL, n, r);
      e = (n < 16) ? (16'hAAAA & (16'h0001 << n)) : 16'h0000;
      chk("channel map", {ext_channel_sel_out, low_ref_sel_out, temp_sensor_sel_out,
        bandgap_sel_out, converter_off_out}, {e, n inside {[16:21], 30}, n == 26, n == 27,
        n == 31});
    end
  endtask
  task automatic t_formats;
    run(5'h03, 10'h2C5);
    no_conv();
    run(5'h12, 10'h000);
    wr(`ADC_OFS_CLKCFG, 32'h0000_0010, r);
    run(5'h03, 10'h0B1);
    // All four sources, each divided by two
    for (int s = 0; s < 4; s++) begin
      wr(`ADC_OFS_CLKCFG, s | 4, r);
      run(5'h03, 10'h2C5);
    end
    wr(`ADC_OFS_CLKCFG, 32'h0000_0000, r);
  endtask
  task automatic t_abort_irq;
    wr(`ADC_OFS_IRQSTAT, 32'h0000_0003, r);
    wr(`ADC_OFS_IRQMASK, 32'h0000_0001, r);
    wr(`ADC_OFS_CTRL, 32'h0000_0003, r);
    wait_done();
    chk("irq raised", irq_out, 32'h1);
    wr(`ADC_OFS_IRQMASK, 32'h0000_0000, r);
    chk("irq masked", irq_out, 32'h0);
    wr(`ADC_OFS_IRQSTAT, 32'h0000_0001, r);
    wr(`ADC_OFS_IRQMASK, 32'h0000_0001, r);
    chk("irq cleared", irq_out, 32'h0);
    wr(`ADC_OFS_CTRL, 32'h0000_0003, r);
    rd(`ADC_OFS_CTRL, d);
    chk("done cleared by write", d[`ADC_CTRL_DONE_BIT], 32'h0);
    rd(`ADC_OFS_TRIG, d);
    chk("restarted", d[`ADC_TRIG_BUSY_BIT], 32'h1);
    wait_done();
    wr(`ADC_OFS_IRQSTAT, 32'h0000_0003, r);
  endtask
  task automatic t_compare;
    wr(`ADC_OFS_CMPVAL, 32'h0000_0300, r);
    wr(`ADC_OFS_TRIG, 32'h0000_0002, r);
    run(5'h03, 10'h2C5);
    rd(`ADC_OFS_IRQSTAT, d);
    chk("compare status", d, 32'h0000_0003);
    wr(`ADC_OFS_IRQSTAT, 32'h0000_0003, r);
    wr(`ADC_OFS_TRIG, 32'h0000_0006, r);
    wr(`ADC_OFS_CTRL, 32'h0000_0003, r);
    no_conv();
    wr(`ADC_OFS_TRIG, 32'h0000_0000, r);
  endtask
  task automatic t_cont_stop;
    wr(`ADC_OFS_CTRL, 32'h0000_0023, r);
    wait_done();
    rd(`ADC_OFS_RESULT, d);
    wait_done();
    wr(`ADC_OFS_CTRL, 32'h0000_001F, r);
    chk("powered down", converter_off_out, 32'h1);
    no_conv();
  endtask
  task automatic t_trigger;
    wr(`ADC_OFS_TRIG, 32'h0000_0001, r);
    wr(`ADC_OFS_CTRL, 32'h0000_0003, r);
    no_conv();
    pulse();
    wait_done();
    wr(`ADC_OFS_CTRL, 32'h0000_0003, r);
    pulse();
    no_conv();
    pulse();
    wait_done();
    wr(`ADC_OFS_TRIG, 32'h0000_0000, r);
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    t_reset();
    t_chan_map();
    t_formats();
    t_abort_irq();
    t_compare();
    t_cont_stop();
    t_trigger();
    report_and_stop();
  end
endmodule // sar_adc_channel_trigger_control_tb_top
